// File: common/pls_pkg.sv
// package: register map, field layouts, timing constants for the supervisor block
package pls_pkg;

  // --------------------------------------------------------------------------
  // clock and timing
  // --------------------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned MIN_OFF_S        = 2;   // least off-time before restart
  localparam int unsigned OVP_RETRY_S      = 1;   // spacing between ovp retries
  localparam int unsigned OVP_WINDOW_S     = 60;  // one minute window
  localparam int unsigned OVP_MAX_TRIES    = 3;
  localparam longint unsigned MIN_OFF_CYC  = longint'(MIN_OFF_S) * CLK_HZ;
  localparam longint unsigned RETRY_CYC    = longint'(OVP_RETRY_S) * CLK_HZ;
  localparam longint unsigned WINDOW_CYC   = longint'(OVP_WINDOW_S) * CLK_HZ;

  // --------------------------------------------------------------------------
  // output-power command values
  // --------------------------------------------------------------------------
  localparam logic [7:0] PWR_CMD_ON  = 8'h80;
  localparam logic [7:0] PWR_CMD_OFF = 8'h00;

  // --------------------------------------------------------------------------
  // register byte addresses
  // --------------------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_IRQ    = 12'h008;
  localparam logic [11:0] ADDR_MASK   = 12'h00C;
  localparam logic [11:0] ADDR_HOSTNV = 12'h100; // 96 bytes, word 0x100..0x15C
  localparam logic [11:0] ADDR_IDNV   = 12'h200; // 128 bytes, 0x200..0x27C

  // control register fields
  localparam int CTRL_PWR_LSB = 0;   // output-power command byte [7:0]
  localparam int CTRL_OC_LAT  = 8;   // 1: overcurrent latches
  localparam int CTRL_OT_LAT  = 9;   // 1: overtemperature latches
  localparam logic [31:0] CTRL_RESET = 32'h0000_0080;

  // irq / mask bits
  localparam int IRQ_W       = 6;
  localparam int IRQ_OVP     = 0;
  localparam int IRQ_OC      = 1;
  localparam int IRQ_OT      = 2;
  localparam int IRQ_INLOSS  = 3;
  localparam int IRQ_LATCH   = 4;
  localparam int IRQ_RESTART = 5;

  localparam int HOSTNV_WORDS = 24;  // 96 bytes
  localparam int IDNV_WORDS   = 32;  // 128 bytes

  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_RETRY   = 2'b01,
    ST_LATCHED = 2'b10,
    ST_OFF     = 2'b11
  } pls_state_t;

  typedef struct packed {
    logic output_overvoltage_trip;
    logic oc;
    logic ot;
    logic input_ok;
  } pls_sense_t;

  typedef struct packed {
    logic input_good_indicator;
    logic output_present_indicator;
    logic fault_indicator;
    logic fault_mon;      // high = no fault
    logic output_good_mon;
    logic input_good_mon;
    logic temp_good_mon;
  } pls_ind_t;

endpackage : pls_pkg

// File: hdl/pls_supervisor.sv
// supervisor: latch-off/restart control, indicators, monitor pins, apb registers
//
// Chosen here: the register addresses and the APB register port.
module pls_supervisor
  import pls_pkg::*;
#(
  parameter longint unsigned MIN_OFF_CYCLES = MIN_OFF_CYC,
  parameter longint unsigned RETRY_CYCLES   = RETRY_CYC,
  parameter longint unsigned WINDOW_CYCLES  = WINDOW_CYC
) (
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // pins
  input  wire logic        enable_n_in,
  input  wire logic        remote_on_in,
  input  wire logic        write_protect_in,
  input  wire pls_sense_t  sense_in,
  output pls_ind_t         ind_out,
  output logic             power_on_out,
  output logic             irq_out
);

  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  // counters are 40 bits wide; larger counts would wrap silently
  if (MIN_OFF_CYCLES < 1 || RETRY_CYCLES < 1 || WINDOW_CYCLES <= RETRY_CYCLES
      || WINDOW_CYCLES > 40'hFF_FFFF_FFFF || MIN_OFF_CYCLES > 40'hFF_FFFF_FFFF) begin : g_bad
    $error("pls_supervisor: bad timing parameters");
  end

  // --------------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------------
  logic        wr_acc;
  logic        rd_acc;
  logic        hit_host;
  logic        hit_id;
  logic        hit_reg;
  logic [4:0]  word_idx;

  assign wr_acc   = psel_in & penable_in & pwrite_in & pready_out;
  assign rd_acc   = psel_in & penable_in & ~pwrite_in & pready_out;
  assign word_idx = paddr_in[6:2];
  assign hit_host = (paddr_in[11:8] == ADDR_HOSTNV[11:8]) && (paddr_in[7] == 1'b0)
                    && (32'(word_idx) < HOSTNV_WORDS) && (paddr_in[1:0] == 2'b00);
  assign hit_id   = (paddr_in[11:7] == ADDR_IDNV[11:7]) && (paddr_in[1:0] == 2'b00);
  assign hit_reg  = (paddr_in == ADDR_CTRL) || (paddr_in == ADDR_STATUS)
                    || (paddr_in == ADDR_IRQ) || (paddr_in == ADDR_MASK);

  // --------------------------------------------------------------------------
  // control and mask registers
  // --------------------------------------------------------------------------
  logic [31:0]        ctrl_reg;
  logic [IRQ_W-1:0]   mask_reg;
  logic [7:0]         pwr_cmd;
  logic               oc_latch_cfg;
  logic               ot_latch_cfg;
  logic               oc_lat_d;
  logic               ot_lat_d;
  logic               cfg_drop;

  assign pwr_cmd      = ctrl_reg[CTRL_PWR_LSB +: 8];
  assign oc_latch_cfg = ctrl_reg[CTRL_OC_LAT];
  assign ot_latch_cfg = ctrl_reg[CTRL_OT_LAT];
  // only a change back to hiccup releases; a steady setting must not undo an ovp latch
  assign cfg_drop     = (oc_lat_d & ~oc_latch_cfg) | (ot_lat_d & ~ot_latch_cfg);

  // previous response bits for the change detector
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      oc_lat_d <= 1'b0;
      ot_lat_d <= 1'b0;
    end else begin
      oc_lat_d <= oc_latch_cfg;
      ot_lat_d <= ot_latch_cfg;
    end
  end

  // only the command byte and two fault-response bits exist; other bits read zero
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_reg <= CTRL_RESET;
      mask_reg <= '0;
    end else if (wr_acc && paddr_in == ADDR_CTRL) begin
      ctrl_reg <= {22'h00_0000, pwdata_in[CTRL_OT_LAT], pwdata_in[CTRL_OC_LAT],
                   pwdata_in[7:0]};
    end else if (wr_acc && paddr_in == ADDR_MASK) begin
      mask_reg <= pwdata_in[IRQ_W-1:0];
    end
  end

  // --------------------------------------------------------------------------
  // nonvolatile stores: host area and write-protected id area
  // --------------------------------------------------------------------------
  logic [31:0] host_mem [HOSTNV_WORDS];
  logic [31:0] id_mem   [IDNV_WORDS];

  // storage array, no reset: contents are kept across restarts
  always_ff @(posedge clk_sys_in) begin
    if (wr_acc && hit_host) begin
      host_mem[word_idx] <= pwdata_in;
    end
    if (wr_acc && hit_id && !write_protect_in) begin
      id_mem[word_idx] <= pwdata_in;
    end
  end

  // --------------------------------------------------------------------------
  // on/off request: pin, enable and command byte
  // --------------------------------------------------------------------------
  logic on_req;
  logic on_req_d;
  logic cmd_on;

  assign cmd_on = (pwr_cmd == PWR_CMD_ON);
  // any value other than the on byte counts as off
  assign on_req = remote_on_in & ~enable_n_in & cmd_on;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      on_req_d <= 1'b0;
    end else begin
      on_req_d <= on_req;
    end
  end

  // --------------------------------------------------------------------------
  // fault response state machine
  // --------------------------------------------------------------------------
  pls_state_t state_reg;
  logic [39:0] tmr_reg;      // off-time / retry delay
  logic [39:0] win_reg;      // ovp window
  logic [1:0]  tries_reg;
  logic        restart_evt;
  logic        latch_evt;
  logic        hiccup_fault;
  logic        ovp_rise;
  logic        ovp_d;

  assign hiccup_fault = (sense_in.oc & ~oc_latch_cfg) | (sense_in.ot & ~ot_latch_cfg);
  assign ovp_rise     = sense_in.output_overvoltage_trip & ~ovp_d;

  // off -> on edge is only honoured after the least off-time has run out
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg   <= ST_OFF;
      tmr_reg     <= '0;
      win_reg     <= '0;
      tries_reg   <= '0;
      ovp_d       <= 1'b0;
      restart_evt <= 1'b0;
      latch_evt   <= 1'b0;
    end else begin
      ovp_d       <= sense_in.output_overvoltage_trip;
      restart_evt <= 1'b0;
      latch_evt   <= 1'b0;
      if (win_reg != '0) begin
        win_reg <= win_reg - 40'd1;
      end else begin
        tries_reg <= '0;
      end
      case (state_reg)
        ST_RUN: begin
          if (!on_req) begin
            state_reg <= ST_OFF;
            tmr_reg   <= 40'(MIN_OFF_CYCLES);
          end else if ((sense_in.oc && oc_latch_cfg) || (sense_in.ot && ot_latch_cfg)) begin
            state_reg <= ST_LATCHED;
            latch_evt <= 1'b1;
          end else if (ovp_rise) begin
            if (win_reg == '0) begin
              win_reg <= 40'(WINDOW_CYCLES);
            end
            if (32'(tries_reg) >= OVP_MAX_TRIES - 1 && win_reg != '0) begin
              state_reg <= ST_LATCHED;
              latch_evt <= 1'b1;
            end else begin
              state_reg <= ST_RETRY;
              tmr_reg   <= 40'(RETRY_CYCLES);
              tries_reg <= tries_reg + 2'd1;
            end
          end
        end
        ST_RETRY: begin
          if (tmr_reg != '0) begin
            tmr_reg <= tmr_reg - 40'd1;
          end else begin
            state_reg <= ST_RUN;
          end
        end
        ST_LATCHED: begin
          if (!on_req) begin
            state_reg <= ST_OFF;
            tmr_reg   <= 40'(MIN_OFF_CYCLES);
          end else if (cfg_drop && !oc_latch_cfg && !ot_latch_cfg && !sense_in.output_overvoltage_trip) begin
            state_reg   <= ST_RUN;
            restart_evt <= 1'b1;
            tries_reg   <= '0;
            win_reg     <= '0;
          end
        end
        ST_OFF: begin
          if (tmr_reg != '0) begin
            tmr_reg <= tmr_reg - 40'd1;
          end else if (on_req && !on_req_d) begin
            state_reg   <= ST_RUN;
            restart_evt <= 1'b1;
            tries_reg   <= '0;
            win_reg     <= '0;
          end
        end
        default: begin
          state_reg <= ST_OFF;
          tmr_reg   <= 40'(MIN_OFF_CYCLES);
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // status, sticky events and interrupt
  // --------------------------------------------------------------------------
  logic [IRQ_W-1:0] irq_reg;
  logic [IRQ_W-1:0] evt;
  logic             fault_any;
  logic             running;

  assign running   = (state_reg == ST_RUN) & ~hiccup_fault & ~sense_in.output_overvoltage_trip;
  assign fault_any = ~sense_in.input_ok | sense_in.output_overvoltage_trip | sense_in.oc | sense_in.ot
                     | (state_reg == ST_LATCHED) | (state_reg == ST_RETRY);
  assign evt = {restart_evt, latch_evt, ~sense_in.input_ok, sense_in.ot, sense_in.oc,
                sense_in.output_overvoltage_trip};

  // a restart wipes all sticky bits; new events on the read cycle still win
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_reg <= '0;
    end else if (restart_evt) begin
      irq_reg <= evt & ~(6'h01 << IRQ_RESTART | 6'h00) | (6'h01 << IRQ_RESTART);
    end else if (rd_acc && paddr_in == ADDR_IRQ) begin
      irq_reg <= evt;
    end else begin
      irq_reg <= irq_reg | evt;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_reg & mask_reg);
    end
  end

  // --------------------------------------------------------------------------
  // indicators and monitoring outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ind_out      <= '{default: 1'b0};
      power_on_out <= 1'b0;
    end else begin
      power_on_out                      <= running;
      ind_out.input_good_indicator      <= sense_in.input_ok;
      ind_out.output_present_indicator  <= running & ~fault_any;
      ind_out.fault_indicator           <= fault_any;
      ind_out.fault_mon                 <= ~fault_any;
      ind_out.output_good_mon           <= running & ~fault_any;
      ind_out.input_good_mon            <= ~fault_any | sense_in.input_ok;
      ind_out.temp_good_mon             <= ~sense_in.ot;
    end
  end

  // --------------------------------------------------------------------------
  // apb read data and handshake
  // --------------------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr_in == ADDR_CTRL) begin
      rd_mux = ctrl_reg;
    end else if (paddr_in == ADDR_STATUS) begin
      rd_mux = {26'h000_0000, state_reg, sense_in.output_overvoltage_trip, sense_in.oc, sense_in.ot,
                sense_in.input_ok};
    end else if (paddr_in == ADDR_IRQ) begin
      rd_mux = {26'h000_0000, irq_reg};
    end else if (paddr_in == ADDR_MASK) begin
      rd_mux = {26'h000_0000, mask_reg};
    end else if (hit_host) begin
      rd_mux = host_mem[word_idx];
    end else if (hit_id) begin
      rd_mux = id_mem[word_idx];
    end
  end

  // one wait state: ready in the second access cycle
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= '0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in & penable_in & ~pready_out;
      prdata_out  <= rd_mux;
      pslverr_out <= psel_in & penable_in & ~pready_out & ~(hit_reg | hit_host | hit_id)
                     | (psel_in & penable_in & ~pready_out & pwrite_in & hit_id
                        & write_protect_in);
    end
  end

endmodule : pls_supervisor

// File: tb/pls_host_model.sv
// host controller model: apb master and discrete on/off pins
module pls_host_model
  import pls_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic      [11:0] paddr_out,
  output logic      [31:0] pwdata_out,
  output logic             remote_on_out,
  output logic             enable_n_out,
  output logic             write_protect_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------------------------------------------------------------
  // idle bus, unit requested on from reset
  // --------------------------------------------------------------------------
  initial begin
    {psel_out, penable_out, pwrite_out, paddr_out, pwdata_out} = '0;
    remote_on_out     = 1'b1;
    enable_n_out      = 1'b0; // low means on
    write_protect_out = 1'b1;
  end

  // one transfer, request held until pready is seen at an edge
  task apb_rw(input logic wr, input logic [11:0] a, input logic [31:0] d,
              output logic [31:0] rd, output logic err);
    @(posedge clk_in);
    psel_out    <= 1'b1;
    pwrite_out  <= wr;
    paddr_out   <= a;
    pwdata_out  <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do @(posedge clk_in); while (pready_in !== 1'b1);
    rd = prdata_in;
    err = pslverr_in;
    psel_out    <= 1'b0;
    penable_out <= 1'b0;
    pwdata_out  <= ~d; // stale data must not pass for valid
  endtask : apb_rw

  // off then on by pin (0), command (1) or enable (2); off time is the caller's
  task off_on(input int path, input logic [31:0] ctrl, input int off_cyc);
    logic [31:0] rd;
    logic        err;
    @(posedge clk_in);
    if (path == 0) remote_on_out <= 1'b0;
    if (path == 2) enable_n_out <= 1'b1;
    if (path == 1) apb_rw(1'b1, ADDR_CTRL, {ctrl[31:8], PWR_CMD_OFF}, rd, err);
    repeat (off_cyc) @(posedge clk_in);
    remote_on_out <= 1'b1;
    enable_n_out  <= 1'b0;
    if (path == 1) apb_rw(1'b1, ADDR_CTRL, {ctrl[31:8], PWR_CMD_ON}, rd, err);
  endtask : off_on

  task set_wp(input logic v);
    @(posedge clk_in);
    write_protect_out <= v;
  endtask : set_wp
endmodule : pls_host_model

// File: tb/pls_supervisor_props.sv
// checker: port-level properties of the supervisor
module pls_supervisor_props
  import pls_pkg::*;
#(
  parameter longint unsigned MIN_OFF_CYCLES = MIN_OFF_CYC,
  parameter longint unsigned RETRY_CYCLES   = RETRY_CYC,
  parameter longint unsigned WINDOW_CYCLES  = WINDOW_CYC
) (
  input wire logic        clk_sys_in,
  input wire logic        nrst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        enable_n_in,
  input wire logic        remote_on_in,
  input wire logic        write_protect_in,
  input wire pls_sense_t  sense_in,
  input wire pls_ind_t    ind_out,
  input wire logic        power_on_out,
  input wire logic        irq_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------------------------------------------------------------
  // properties: outputs are registered, four steady cycles give them margin
  // --------------------------------------------------------------------------
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  // any live overvoltage, overcurrent or overtemperature sense
  wire logic any_fault = sense_in.output_overvoltage_trip | sense_in.oc | sense_in.ot;

  temp_good_a: assert property (!sense_in.ot [*4] |-> ind_out.temp_good_mon)
    else $error("temperature-good low without overtemperature");
  temp_low_a: assert property (sense_in.ot [*4] |-> !ind_out.temp_good_mon)
    else $error("temperature-good high during overtemperature");
  input_lamp_a: assert property (sense_in.input_ok [*4] |-> ind_out.input_good_indicator)
    else $error("input indicator off with good input");
  input_loss_a: assert property ((!sense_in.input_ok && !sense_in.ot) [*4] |->
    !ind_out.input_good_indicator && !ind_out.fault_mon && !ind_out.output_good_mon
    && !ind_out.input_good_mon && ind_out.temp_good_mon)
    else $error("wrong outputs on input loss");
  fault_show_a: assert property (any_fault [*4] |-> ind_out.fault_indicator &&
    !ind_out.fault_mon && !ind_out.output_good_mon && !ind_out.output_present_indicator)
    else $error("fault not shown");
  normal_a: assert property ((power_on_out && sense_in == 4'h1) [*4] |-> ind_out == 7'h6F)
    else $error("normal indicator pattern wrong");
  enable_off_a: assert property (enable_n_in [*4] |-> !power_on_out)
    else $error("output on while enable high");
  ready_gap_a: assert property (psel_in && $rose(penable_in) |-> !pready_out ##1 pready_out)
    else $error("apb answer not after one wait state");
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  slverr_with_a: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");

  restart_c: cover property ($rose(power_on_out));
  irq_c: cover property ($rose(irq_out));
  refused_c: cover property (pslverr_out);
endmodule : pls_supervisor_props

bind pls_supervisor pls_supervisor_props #(
  .MIN_OFF_CYCLES(MIN_OFF_CYCLES), .RETRY_CYCLES(RETRY_CYCLES), .WINDOW_CYCLES(WINDOW_CYCLES)
) pls_supervisor_props_inst (
  .clk_sys_in, .nrst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
  .prdata_out, .pready_out, .pslverr_out, .enable_n_in, .remote_on_in,
  .write_protect_in, .sense_in, .ind_out, .power_on_out, .irq_out
);

// File: tb/tb.sv
// testbench: supervisor with host model, sense stimulus and checker
module tb
  import pls_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------------------------------------------------------------
  // short counts keep the run brief
  // --------------------------------------------------------------------------
  localparam int OFFC = 20;
  localparam int RETC = 10;
  localparam pls_sense_t GOOD = 4'h1;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  pls_sense_t sense_in = GOOD;
  logic psel_in, penable_in, pwrite_in, pready_out, pslverr_out, power_on_out, irq_out;
  logic remote_on_in, enable_n_in, write_protect_in, rerr;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rdata;
  pls_ind_t ind_out;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;

  always #5 clk_sys_in = ~clk_sys_in;

  pls_supervisor #(.MIN_OFF_CYCLES(OFFC), .RETRY_CYCLES(RETC), .WINDOW_CYCLES(200))
    pls_supervisor_inst (.clk_sys_in, .nrst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .enable_n_in, .remote_on_in,
    .write_protect_in, .sense_in, .ind_out, .power_on_out, .irq_out);

  pls_host_model pls_host_model_inst (.clk_in(clk_sys_in), .prdata_in(prdata_out),
    .pready_in(pready_out), .pslverr_in(pslverr_out), .psel_out(psel_in),
    .penable_out(penable_in), .pwrite_out(pwrite_in), .paddr_out(paddr_in),
    .pwdata_out(pwdata_in), .remote_on_out(remote_on_in), .enable_n_out(enable_n_in),
    .write_protect_out(write_protect_in));

  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  // hang guard, generous over the roughly 430 cycles needed
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      print_verdict();
    end
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task wc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : wc

  task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    pls_host_model_inst.apb_rw(w, a, d, rdata, rerr);
  endtask : acc

  task pulse(input pls_sense_t s);
    @(posedge clk_sys_in);
    sense_in <= s;
    wc(4);
    sense_in <= GOOD;
    wc(6);
  endtask : pulse

  task latched;
    acc(1'b0, ADDR_STATUS, '0);
    chk("latched state", 32'h2, rdata[5:4]);
    chk("output off", 32'h0, power_on_out);
  endtask : latched

  task t_reg;
    acc(1'b0, ADDR_CTRL, '0);
    chk("ctrl reset", CTRL_RESET, rdata);
    acc(1'b1, 12'h15C, 32'hA5A5_5A5A);
    acc(1'b0, 12'h15C, '0);
    chk("host store", 32'hA5A5_5A5A, rdata);
    pls_host_model_inst.set_wp(1'b0);
    acc(1'b1, 12'h27C, 32'h1234_5678);
    pls_host_model_inst.set_wp(1'b1);
    acc(1'b1, 12'h27C, 32'hFFFF_0000);
    chk("id write refused", 32'h1, rerr);
    acc(1'b0, 12'h27C, '0);
    chk("id store", 32'h1234_5678, rdata);
    acc(1'b0, 12'h160, '0);
    chk("past host store", 32'h1, rerr);
    acc(1'b0, 12'h280, '0);
    chk("past id store", 32'h1, rerr);
    $display("test registers done");
  endtask : t_reg

  task t_table;
    pls_sense_t cond [3];
    logic [6:0] want [3];
    logic       pwr  [3];
    cond = '{4'h0, 4'h5, 4'h3}; // input loss, overcurrent, overtemperature
    want = '{7'h11, 7'h53, 7'h52};
    pwr  = '{1'b1, 1'b0, 1'b0}; // converter stays enabled on input loss; hiccup gates it
    chk("normal indicators", 32'h6F, ind_out);
    acc(1'b1, ADDR_MASK, '0);
    for (int i = 0; i < 3; i++) begin
      sense_in <= cond[i];
      wc(6);
      chk("alarm indicators", want[i], ind_out);
      chk("output enable", {31'h0, pwr[i]}, power_on_out);
      sense_in <= GOOD;
      wc(10);
    end
    chk("masked irq", 32'h0, irq_out);
    acc(1'b1, ADDR_MASK, 32'h0000_003F);
    wc(3);
    chk("irq raised", 32'h1, irq_out);
    acc(1'b0, ADDR_IRQ, '0);
    chk("irq events", 32'h7, rdata[3:1]);
    wc(3);
    chk("irq cleared", 32'h0, irq_out);
    $display("test alarm table done");
  endtask : t_table

  task t_latch_oc;
    pls_host_model_inst.off_on(0, CTRL_RESET, OFFC + 5);
    wc(5);
    chk("running", 32'h1, power_on_out);
    acc(1'b1, ADDR_CTRL, 32'h0000_0180);
    pulse(4'h5);
    latched();
    pls_host_model_inst.off_on(0, CTRL_RESET, 5);
    wc(10);
    chk("short off ignored", 32'h0, power_on_out);
    pls_host_model_inst.off_on(0, CTRL_RESET, OFFC + 5);
    wc(5);
    chk("pin restart", 32'h1, power_on_out);
    acc(1'b0, ADDR_IRQ, '0);
    chk("irq after restart", 32'h20, rdata);
    wc(3);
    chk("irq low after read", 32'h0, irq_out);
    $display("test latched overcurrent done");
  endtask : t_latch_oc

  task t_latch_ot;
    acc(1'b1, ADDR_CTRL, 32'h0000_0280);
    pulse(4'h3);
    latched();
    pls_host_model_inst.off_on(1, 32'h0000_0280, OFFC + 5);
    wc(5);
    chk("command restart", 32'h1, power_on_out);
    pulse(4'h3);
    latched();
    acc(1'b1, ADDR_CTRL, CTRL_RESET);
    wc(3);
    chk("hiccup restart", 32'h1, power_on_out);
    acc(1'b0, ADDR_IRQ, '0);
    chk("irq after restart", 32'h20, rdata);
    $display("test latched overtemperature done");
  endtask : t_latch_ot

  task t_ovp;
    for (int i = 0; i < 3; i++) begin
      pulse(4'h9);
      wc(RETC + 6);
      chk("ovp retry", {31'h0, i < 2}, power_on_out);
    end
    latched();
    pls_host_model_inst.off_on(2, CTRL_RESET, OFFC + 5);
    wc(5);
    chk("enable restart", 32'h1, power_on_out);
    $display("test overvoltage done");
  endtask : t_ovp

  // main sequence
  initial begin
    wc(10);
    nrst_in <= 1'b1;
    wc(3);
    t_reg();
    t_table();
    t_latch_oc();
    t_latch_ot();
    t_ovp();
    print_verdict();
  end
endmodule : tb
